/* File: tsw_pkg.sv */
// Constants shared by the time-slot switch memory map block.
package tsw_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int SPACE_BIT = 14;
  localparam int STREAM_HI = 13;
  localparam int STREAM_LO = 9;
  localparam int CHAN_HI = 8;
  localparam int CHAN_LO = 0;
  localparam logic [14:0] CTRL_OFFSET = 15'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int MS_LSB = 0;
  localparam logic [2:0] MS_LOCAL_ROUTE = 3'h0;
  localparam logic [2:0] MS_BACK_ROUTE = 3'h1;
  localparam logic [2:0] MS_LOCAL_DATA = 3'h2;
  localparam logic [2:0] MS_BACK_DATA = 3'h3;
  localparam int SRC_BIT = 15;
  localparam int MSG_BIT = 14;
  localparam int EN_BIT = 13;
  localparam int SSTREAM_HI = 12;
  localparam int SSTREAM_LO = 8;
  localparam logic [15:0] ROUTE_RESET = 16'h0000;
  localparam int CLK_NS = 25;
  localparam int BIT_NS = 488;
  localparam int BIT_CYCLES = BIT_NS / CLK_NS;
endpackage

/* File: tsw_memmap.sv */
// Host memory map, receive byte stores and local output route words.
`timescale 1ns/1ps
// Summary of operation
// - Address bit 14 high reaches a memory, low reaches the register space.
// - Memory select field of the control register chooses the target memory.
// - Memory address bits 13 to 9 are the stream index 0 to 31.
// - Memory address bits 8 to 0 are the channel index; only 0 to 255 are accepted.
// - Each received timeslot becomes a byte stored in its side's store.
// - Local receive store holds 8192 bytes and is read-only to the host.
// - Backplane receive store holds 8192 bytes and is read-only too.
// - Store reads return the byte in bits 7:0 and zero above.
// - The first received bit of a timeslot lands in byte bit 7.
// - Local route memory holds 8192 words indexed by stream and channel.
// - Route bit 15 picks local (1) or backplane (0) data, unless message.
// - Route bit 14 selects message mode instead of switched data.
// - Message mode sends the route word's low byte on the timeslot.
// - Message and switched bytes are both shifted out bit 7 first.
// - Route bit 13 enables the channel; else tristate or buffer flag.
// - Route bits 12:8 give the source stream when switching.
// - Route bits 7:0 give the source channel when switching.
module tsw_memmap #(
  parameter int STREAMS = 32,
  parameter int CHANNELS = 256,
  parameter int BIT_DIV = tsw_pkg::BIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic [tsw_pkg::ADDR_W-1:0] host_addr,
  input wire logic [tsw_pkg::DATA_W-1:0] host_wdata,
  output logic [tsw_pkg::DATA_W-1:0] host_rdata,
  output logic host_ack,
  input wire logic [STREAMS-1:0] local_rx_pins,
  input wire logic [STREAMS-1:0] backplane_rx_pins,
  input wire logic local_output_reset_state_pin,
  output logic [STREAMS-1:0] local_serial_outputs,
  output logic [STREAMS-1:0] local_serial_oe_n,
  output logic [STREAMS-1:0] local_ext_buffer_off
);
  localparam int DEPTH = 8192;
  localparam int DIV_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Index helper: stream and channel form one store address.
  function automatic logic [12:0] store_idx(input logic [4:0] strm,
                                            input logic [7:0] chan);
    store_idx = {strm, chan};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [STREAMS-1:0] lrx_m, lrx_s, brx_m, brx_s;
  logic local_output_reset_state_pin_m, local_output_reset_state_pin_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lrx_m <= '0;
      lrx_s <= '0;
      brx_m <= '0;
      brx_s <= '0;
      local_output_reset_state_pin_m <= 1'b0;
      local_output_reset_state_pin_s <= 1'b0;
    end else begin
      lrx_m <= local_rx_pins;
      lrx_s <= lrx_m;
      brx_m <= backplane_rx_pins;
      brx_s <= brx_m;
      local_output_reset_state_pin_m <= local_output_reset_state_pin;
      local_output_reset_state_pin_s <= local_output_reset_state_pin_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing: divider enable, bit and channel counters.
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] chan_cnt, next_chan_cnt;
  logic bit_tick, byte_done;
  logic [7:0] chan_next;

  always_comb begin
    bit_tick = (div_cnt == DIV_W'(BIT_DIV - 1));
    byte_done = bit_tick && (bit_cnt == 3'h7);
    next_div_cnt = bit_tick ? '0 : div_cnt + 1'b1;
    next_bit_cnt = bit_tick ? bit_cnt + 1'b1 : bit_cnt;
    chan_next = (chan_cnt == 8'(CHANNELS - 1)) ? 8'h00 : chan_cnt + 8'h01;
    next_chan_cnt = byte_done ? chan_next : chan_cnt;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      bit_cnt <= 3'h0;
      chan_cnt <= 8'h00;
    end else begin
      div_cnt <= next_div_cnt;
      bit_cnt <= next_bit_cnt;
      chan_cnt <= next_chan_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side: serial to parallel, first bit ends in bit 7.
  logic [7:0] lsh [STREAMS];
  logic [7:0] bsh [STREAMS];
  logic [7:0] next_lsh [STREAMS];
  logic [7:0] next_bsh [STREAMS];
  logic [7:0] lstore [DEPTH];
  logic [7:0] bstore [DEPTH];

  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      next_lsh[s] = bit_tick ? {lsh[s][6:0], lrx_s[s]} : lsh[s];
      next_bsh[s] = bit_tick ? {bsh[s][6:0], brx_s[s]} : bsh[s];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < STREAMS; s++) begin
        lsh[s] <= 8'h00;
        bsh[s] <= 8'h00;
      end
    end else begin
      for (int s = 0; s < STREAMS; s++) begin
        lsh[s] <= next_lsh[s];
        bsh[s] <= next_bsh[s];
      end
    end
  end

  // Only the receive converters write the stores; the host cannot.
  always_ff @(posedge core_clk) begin
    if (byte_done) begin
      for (int s = 0; s < STREAMS; s++) begin
        lstore[store_idx(5'(s), chan_cnt)] <= next_lsh[s];
        bstore[store_idx(5'(s), chan_cnt)] <= next_bsh[s];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host port: control register, route memory, store reads.
  logic [15:0] ctrl, next_ctrl;
  logic [15:0] route [DEPTH];
  logic [15:0] next_rdata;
  logic next_ack;
  logic mem_sp, chan_ok, route_we;
  logic [2:0] ms;
  logic [12:0] hidx;

  always_comb begin
    ms = ctrl[tsw_pkg::MS_LSB +: 3];
    mem_sp = host_addr[tsw_pkg::SPACE_BIT];
    chan_ok = !host_addr[tsw_pkg::CHAN_HI];
    hidx = store_idx(host_addr[tsw_pkg::STREAM_HI:tsw_pkg::STREAM_LO],
                     host_addr[7:tsw_pkg::CHAN_LO]);
    route_we = host_sel && host_wr && mem_sp && chan_ok &&
               (ms == tsw_pkg::MS_LOCAL_ROUTE);
    next_ctrl = ctrl;
    next_rdata = 16'h0000;
    next_ack = host_sel;
    if (host_sel && !mem_sp) begin
      if (host_addr == tsw_pkg::CTRL_OFFSET) begin
        if (host_wr) begin
          next_ctrl = host_wdata;
        end else begin
          next_rdata = ctrl;
        end
      end
    end else if (host_sel && !host_wr && chan_ok) begin
      if (ms == tsw_pkg::MS_LOCAL_ROUTE) begin
        next_rdata = route[hidx];
      end else if (ms == tsw_pkg::MS_LOCAL_DATA) begin
        next_rdata = {8'h00, lstore[hidx]};
      end else if (ms == tsw_pkg::MS_BACK_DATA) begin
        next_rdata = {8'h00, bstore[hidx]};
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= tsw_pkg::CTRL_RESET;
      host_rdata <= 16'h0000;
      host_ack <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      host_rdata <= next_rdata;
      host_ack <= next_ack;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        route[i] <= tsw_pkg::ROUTE_RESET;
      end
    end else if (route_we) begin
      route[hidx] <= host_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local output side: pick the byte per channel and shift it out.
  logic [15:0] rword [STREAMS];
  logic [7:0] sel_byte [STREAMS];
  logic [7:0] obyte [STREAMS];
  logic [7:0] next_obyte [STREAMS];
  logic [STREAMS-1:0] oen, next_oen;
  logic [12:0] sidx;

  always_comb begin
    sidx = 13'h0000;
    for (int s = 0; s < STREAMS; s++) begin
      rword[s] = route[store_idx(5'(s), chan_next)];
      sidx = store_idx(rword[s][tsw_pkg::SSTREAM_HI:tsw_pkg::SSTREAM_LO],
                       rword[s][7:0]);
      if (rword[s][tsw_pkg::MSG_BIT]) begin
        sel_byte[s] = rword[s][7:0];
      end else if (rword[s][tsw_pkg::SRC_BIT]) begin
        sel_byte[s] = lstore[sidx];
      end else begin
        sel_byte[s] = bstore[sidx];
      end
      if (byte_done) begin
        next_obyte[s] = sel_byte[s];
        next_oen[s] = rword[s][tsw_pkg::EN_BIT];
      end else begin
        next_obyte[s] = bit_tick ? {obyte[s][6:0], 1'b0} : obyte[s];
        next_oen[s] = oen[s];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oen <= '0;
      for (int s = 0; s < STREAMS; s++) begin
        obyte[s] <= 8'h00;
      end
    end else begin
      oen <= next_oen;
      for (int s = 0; s < STREAMS; s++) begin
        obyte[s] <= next_obyte[s];
      end
    end
  end

  // A disabled channel floats, or drives high with the buffer flag raised.
  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      local_serial_outputs[s] = oen[s] ? obyte[s][7] : 1'b1;
      local_serial_oe_n[s] = !(oen[s] || local_output_reset_state_pin_s);
      local_ext_buffer_off[s] = !oen[s] && local_output_reset_state_pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // The latest route write is kept so that any later read of it is checked.
  logic [14:0] chk_addr, next_chk_addr;
  logic [15:0] chk_data, next_chk_data;
  logic chk_valid, next_chk_valid;

  always_comb begin
    next_chk_addr = route_we ? host_addr : chk_addr;
    next_chk_data = route_we ? host_wdata : chk_data;
    next_chk_valid = chk_valid || route_we;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chk_addr <= 15'h0000;
      chk_data <= 16'h0000;
      chk_valid <= 1'b0;
    end else begin
      chk_addr <= next_chk_addr;
      chk_data <= next_chk_data;
      chk_valid <= next_chk_valid;
    end
  end

  sequence s_route_rd;
    host_sel && !host_wr && host_addr[tsw_pkg::SPACE_BIT] &&
    ms == tsw_pkg::MS_LOCAL_ROUTE;
  endsequence
  sequence s_last_wr_hit;
    chk_valid && host_addr == chk_addr;
  endsequence

  a_route_read_back: assert property (@(posedge core_clk) disable iff (rst)
    s_route_rd ##0 s_last_wr_hit |=> host_rdata == $past(chk_data))
    else $error("route word read back differs from write");
  a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    host_sel |=> host_ack ##1 (host_ack == $past(host_sel)))
    else $error("host ack not one cycle after select");
  a_ctrl_reg_write: assert property (@(posedge core_clk) disable iff (rst)
    host_sel && host_wr && host_addr == tsw_pkg::CTRL_OFFSET
    |=> ms == $past(host_wdata[2:0]))
    else $error("control write did not reach memory select");
  a_mem_space_keeps: assert property (@(posedge core_clk) disable iff (rst)
    host_sel && host_addr[tsw_pkg::SPACE_BIT] |=> ctrl == $past(ctrl))
    else $error("memory access changed the control register");
  a_store_upper_zero: assert property (@(posedge core_clk) disable iff (rst)
    host_sel && !host_wr && host_addr[tsw_pkg::SPACE_BIT] &&
    (ms == tsw_pkg::MS_LOCAL_DATA || ms == tsw_pkg::MS_BACK_DATA)
    |=> host_rdata[15:8] == 8'h00)
    else $error("store read has nonzero upper byte");
  a_store_write: assert property (@(posedge core_clk) disable iff (rst)
    byte_done |=> lstore[store_idx(5'h00, $past(chan_cnt))] ==
    {$past(lsh[0][6:0]), $past(lrx_s[0])})
    else $error("received byte not stored");
  a_msg_byte_load: assert property (@(posedge core_clk) disable iff (rst)
    byte_done && rword[0][tsw_pkg::MSG_BIT]
    |=> obyte[0] == $past(rword[0][7:0]))
    else $error("message byte not loaded");
  a_msb_first_out: assert property (@(posedge core_clk) disable iff (rst)
    byte_done ##1 oen[0] |-> local_serial_outputs[0] == obyte[0][7])
    else $error("output not msb first");
  a_disable_float: assert property (@(posedge core_clk) disable iff (rst)
    !oen[0] && !local_output_reset_state_pin_s |-> local_serial_oe_n[0] && !local_ext_buffer_off[0])
    else $error("disabled channel is driven");
  a_switch_local: assert property (@(posedge core_clk) disable iff (rst)
    byte_done && !rword[2][tsw_pkg::MSG_BIT] && rword[2][tsw_pkg::SRC_BIT]
    |=> obyte[2] == $past(lstore[store_idx(rword[2][12:8], rword[2][7:0])]))
    else $error("local source byte not selected");
endmodule // tsw_memmap

/* File: tsw_host_model.sv */
// Host bus model issuing single word accesses to the memory map.
`timescale 1ns/1ps
module tsw_host_model (
  input wire logic core_clk,
  output logic host_sel,
  output logic host_wr,
  output logic [14:0] host_addr,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic host_ack
);
  initial begin
    host_sel = 1'b0;
    host_wr = 1'b0;
    host_addr = 15'h0000;
    host_wdata = 16'h0000;
  end
  // Address and data lines show inverted values outside the strobe; host_wr keeps its last value.
  task automatic access(input logic wr, input logic [14:0] addr,
                        input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic ok);
    ok = 1'b0;
    rdata = 16'h0000;
    @(posedge core_clk);
    host_sel <= 1'b1;
    host_wr <= wr;
    host_addr <= addr;
    host_wdata <= wdata;
    @(posedge core_clk);
    host_sel <= 1'b0;
    host_addr <= ~addr;
    host_wdata <= ~wdata;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge core_clk);
      if (host_ack === 1'b1) begin
        ok = 1'b1;
        rdata = host_rdata;
      end
    end
  endtask
  // The memory select field must be set before any memory access.
  task automatic select(input logic [2:0] ms, output logic ok);
    logic [15:0] d;
    access(1'b1, tsw_pkg::CTRL_OFFSET, {13'h0000, ms}, d, ok);
  endtask
endmodule // tsw_host_model

/* File: tsw_memmap_tb.sv */
// Self-checking testbench for the memory map block.
`timescale 1ns/1ps
module tsw_memmap_tb;
  localparam int CHN = 4;
  localparam int DIV = 2;
  localparam int WIN = 2 * CHN * 8 * DIV;
  logic core_clk, rst, host_sel, host_wr, host_ack, rsp;
  logic [14:0] host_addr;
  logic [15:0] host_wdata, host_rdata, rd;
  logic [31:0] lrx, brx, sout, oe_n, boff;
  logic ok;
  int bad_count, checked, ones, run, drv;
  logic [15:0] msg [4] = '{16'h600f, 16'h60f0, 16'h6000, 16'h6000};

  tsw_memmap #(.STREAMS(32), .CHANNELS(CHN), .BIT_DIV(DIV)) i_dut (
    .core_clk(core_clk), .rst(rst), .host_sel(host_sel),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_ack(host_ack), .local_rx_pins(lrx),
    .backplane_rx_pins(brx), .local_output_reset_state_pin(rsp),
    .local_serial_outputs(sout), .local_serial_oe_n(oe_n),
    .local_ext_buffer_off(boff));
  tsw_host_model i_host (
    .core_clk(core_clk), .host_sel(host_sel), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_ack(host_ack));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [14:0] ma(input int s, input int c);
    return {1'b1, s[4:0], c[8:0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic acked();
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t no acknowledge", $time);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    i_host.access(1'b1, a, d, rd, ok);
    acked();
  endtask
  task automatic rdc(input logic [14:0] a, input logic [15:0] exp);
    i_host.access(1'b0, a, 16'h0000, rd, ok);
    acked();
    check(rd, exp);
  endtask
  task automatic sel(input logic [2:0] ms);
    i_host.select(ms, ok);
    acked();
  endtask
  // Counts ones, longest run of ones and driven cycles over two frames.
  task automatic measure(input int s);
    int r;
    ones = 0;
    run = 0;
    drv = 0;
    r = 0;
    repeat (WIN) begin
      @(posedge core_clk);
      r = (sout[s] === 1'b1) ? r + 1 : 0;
      ones += (sout[s] === 1'b1);
      drv += (oe_n[s] === 1'b0);
      if (r > run) run = r;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    rsp = 1'b0;
    lrx = 32'h0000_0008;
    brx = 32'h0000_0020;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    sel(3'h0);
    for (int c = 0; c < CHN; c++) begin
      wr(ma(0, c), msg[c]);
      wr(ma(2, c), 16'ha300 | c[15:0]);
      wr(ma(4, c), 16'h2300 | c[15:0]);
    end
    rdc(ma(0, 1), 16'h60f0);
    rdc(ma(4, 3), 16'h2303);
    wr(ma(0, 256), 16'hffff);
    rdc(ma(0, 256), 16'h0000);
    rdc(ma(0, 0), 16'h600f);
    wr(15'h0001, 16'h1234);
    rdc(15'h0005, 16'h0000);
    rdc(ma(0, 1), 16'h60f0);
    rdc(ma(1, 0), 16'h0000);
    $display("test host route words done");
    repeat (WIN) @(posedge core_clk);
    measure(0);
    check(16'(run), 16'(8 * DIV));
    check(16'(ones), 16'(WIN / CHN));
    check(16'(drv), 16'(WIN));
    measure(2);
    check(16'(ones), 16'(WIN));
    check(16'(drv), 16'(WIN));
    measure(4);
    check(16'(ones), 16'h0000);
    check(16'(drv), 16'(WIN));
    measure(1);
    check(16'(ones), 16'(WIN));
    check(16'(drv), 16'h0000);
    rsp <= 1'b1;
    repeat (4) @(posedge core_clk);
    check({14'h0000, boff[1], oe_n[1]}, 16'h0002);
    check({15'h0000, boff[0]}, 16'h0000);
    $display("test serial outputs done");
    sel(3'h2);
    rdc(15'h0000, 16'h0002);
    for (int c = 0; c < CHN; c++) begin
      rdc(ma(3, c), 16'h00ff);
      rdc(ma(5, c), 16'h0000);
    end
    wr(ma(3, 1), 16'h1234);
    rdc(ma(3, 1), 16'h00ff);
    sel(3'h3);
    rdc(ma(5, 2), 16'h00ff);
    rdc(ma(3, 2), 16'h0000);
    wr(ma(5, 2), 16'h0000);
    rdc(ma(5, 2), 16'h00ff);
    sel(3'h1);
    rdc(ma(0, 0), 16'h0000);
    $display("test receive stores done");
    give_verdict();
  end
endmodule // tsw_memmap_tb
